// *** design/acq_sequencer.sv ***
// Purpose: acquisition cycle sequencer with single and repeating strobes
// Assumes: classic Wishbone slave; 40 MHz clock; trigger pin synchronous
// Notes:   phases are timed on a microsecond grid aligned to time zero
// Notes on behaviour
// R1: edge mode: only a rising external trigger starts a cycle at time zero.
// R2: the trigger source holds the input high at least 10 ns.
// R3: internal trigger event follows the rising edge by 20 to 30 ns.
// R4: phases run initial busy plus delay, integration, final busy, then end.
// R5: acquisition delay is 0 to 335500 us in 1 us steps.
// R6: variant 0: integration 1 us..6 s, busy1 rule by 218 us, busy2 218 us.
// R7: variant 1: both busy times 3706 us, integration 3800 us..10 s.
// R8: variant 2: busy1 15 ns, busy2 4977 us, integration 7200 us..5 s.
// R9: single strobe rises when its delay, counted from the event, expires.
// R10: single strobe stays high for its programmed width.
// R11: single strobe is forced low at the end of integration.
// R12: repeating strobe starts with integration and is idle outside it.
// R13: only whole repeating periods are emitted inside integration.
// R14: repeating period programmable from 0; active only if below integration.
// R15: mode 0 software command, 1 external rising edge, 2 level; level mode starts no cycle here.
// R16: host issues a trigger command per cycle; software mode after reset.
// R17: repeating strobe is 50% duty and low once a period no longer fits; odd periods stay high one microsecond longer than low.
// R18: after a cycle, the spectrum is handed over before a new trigger.
// R19: a 1 us tick comes from the clock; trigger is sampled first.
// R20: sensor variant is a build parameter choosing busy times and limits.
`include "acq_timing_map.svh"
module acq_sequencer
	import acq_timing_pkg::*;
#(
	parameter int VARIANT = 0,
	parameter int TW      = 24
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	// wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire acq_timing_pkg::word_t wb_dat_i,
	output acq_timing_pkg::word_t      wb_dat_o,
	output logic                       wb_ack_o,
	// trigger pin and outputs
	input  wire logic                  ext_trig_in,
	output logic                       single_strobe,
	output logic                       repeating_strobe,
	output logic                       acq_busy
);
	import acq_timing_pkg::*;
	localparam int EW = TW + 1;
	localparam logic [1:0] LEAD_CYC = (VARIANT == 2) ? 2'(`ACQ_V2_BUSY1_CYC) : 2'h0; // R8
	localparam logic [TW-1:0] FINAL_BUSY_US = (VARIANT == 0) ? TW'(`ACQ_V0_BUSY2_US) :
		(VARIANT == 1) ? TW'(`ACQ_V1_BUSY2_US) : TW'(`ACQ_V2_BUSY2_US); // R6 R7 R8
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	trig_mode_t    mode;
	seq_state_t    state;
	logic [TW-1:0] cfg [`ACQ_CFG_COUNT];
	logic [1:0]    lead_cnt;
	logic [EW-1:0] elapsed, next_el, b1, b2, b3;
	logic [EW-1:0] next_b1, next_b2, next_b3;
	logic [TW-1:0] ssd, ssw, per, cs_pos, cs_hi;
	logic [TW-1:0] next_integ, next_acq;
	logic          cs_ok, next_cs_ok, cs_live;
	logic          req, wr, sw_go, xfer_ack, edge_evt, go, restart, tick, in_integ;
	word_t         rd_word;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// byte-lane merge of a write into a narrow register
	function automatic logic [TW-1:0] merge(input logic [TW-1:0] old, input word_t d,
		input logic [3:0] sel);
		logic [TW-1:0] r;
		r = old;
		for (int i = 0; i < TW / 8; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge
	// index of a configuration register, or count when not one
	function automatic int cfg_index(input logic [7:0] adr);
		return (adr >= `ACQ_REG_ACQ_DELAY && adr <= `ACQ_REG_RP_PERIOD && adr[1:0] == 2'h0) ?
			int'(adr[7:2]) - 1 : `ACQ_CFG_COUNT;
	endfunction : cfg_index
	// integration time held to the variant's limits
	function automatic logic [TW-1:0] clamp_integ(input logic [TW-1:0] v);
		logic [TW-1:0] lo, hi;
		lo = (VARIANT == 0) ? TW'(`ACQ_V0_INTEG_MIN_US) :
			(VARIANT == 1) ? TW'(`ACQ_V1_INTEG_MIN_US) : TW'(`ACQ_V2_INTEG_MIN_US); // R6 R7 R8
		hi = (VARIANT == 0) ? TW'(`ACQ_V0_INTEG_MAX_US) :
			(VARIANT == 1) ? TW'(`ACQ_V1_INTEG_MAX_US) : TW'(`ACQ_V2_INTEG_MAX_US);
		return (v < lo) ? lo : (v > hi) ? hi : v; // R20
	endfunction : clamp_integ

	// initial busy in microseconds; variant 2 uses lead cycles instead
	function automatic logic [TW-1:0] busy1_us(input logic [TW-1:0] integ);
		if (VARIANT == 0) begin
			return (integ >= TW'(`ACQ_V0_BUSY_SPLIT_US)) ? TW'(`ACQ_V0_BUSY1_MIN_US) :
				TW'(`ACQ_V0_BUSY1_BASE_US) - integ; // R6
		end
		return (VARIANT == 1) ? TW'(`ACQ_V1_BUSY1_US) : '0; // R7 R8
	endfunction : busy1_us

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	trig_edge u_trig (
		.clk         (clk),
		.rst_b       (rst_b),
		.ext_trig_in (ext_trig_in),
		.enable      (mode == TRIG_EDGE),
		.trig_event  (edge_evt)
	);

	us_tick #(.DIV(`ACQ_CYC_PER_US)) u_tick (
		.clk     (clk),
		.rst_b   (rst_b),
		.restart (restart),
		.tick    (tick)
	);

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	// request decode and command pulses
	assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr       = req && wb_we_i;
	assign sw_go    = wr && wb_adr_i == `ACQ_REG_CTRL && wb_sel_i[0] &&
		wb_dat_i[`ACQ_CTRL_SWTRIG_BIT];
	assign xfer_ack = wr && wb_adr_i == `ACQ_REG_CTRL && wb_sel_i[1] &&
		wb_dat_i[`ACQ_CTRL_XFER_BIT];

	// read multiplexer, unmapped reads as zero
	always_comb begin
		rd_word = '0;
		case (wb_adr_i)
			`ACQ_REG_CTRL: rd_word[1:0] = mode;
			`ACQ_REG_STATUS: begin
				rd_word[`ACQ_ST_BUSY_BIT]  = state != S_IDLE;
				rd_word[`ACQ_ST_INTEG_BIT] = in_integ;
				rd_word[`ACQ_ST_XFER_BIT]  = state == S_XFER;
				rd_word[`ACQ_ST_CSOK_BIT]  = cs_ok;
			end
			default: begin
				if (cfg_index(wb_adr_i) < `ACQ_CFG_COUNT) begin
					rd_word[TW-1:0] = cfg[cfg_index(wb_adr_i)];
				end
			end
		endcase
	end

	// acknowledge and read data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req;
			if (req) begin
				wb_dat_o <= rd_word;
			end
		end
	end

	// trigger mode, software mode after reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode <= TRIG_SOFT; // R16
		end else if (wr && wb_adr_i == `ACQ_REG_CTRL && wb_sel_i[0]) begin
			mode <= trig_mode_t'(wb_dat_i[1:0]); // R15
		end
	end

	// configuration store
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < `ACQ_CFG_COUNT; i++) begin
				cfg[i] <= `ACQ_CFG_RESET;
			end
		end else if (wr && cfg_index(wb_adr_i) < `ACQ_CFG_COUNT) begin
			cfg[cfg_index(wb_adr_i)] <= merge(cfg[cfg_index(wb_adr_i)], wb_dat_i, wb_sel_i);
		end
	end

	// ----------------------------------------------------------------
	// cycle sequencing
	// ----------------------------------------------------------------
	// trigger source selection; level mode starts nothing
	assign go = state == S_IDLE &&
		((mode == TRIG_SOFT && sw_go) || (mode == TRIG_EDGE && edge_evt)); // R15 R1 R18
	assign restart  = state == S_LEAD && lead_cnt == 2'h0;
	assign next_el  = elapsed + 1'b1;
	assign in_integ = state == S_RUN && elapsed >= b1 && elapsed < b2;

	// phase boundaries from the programmed values
	always_comb begin
		next_integ = clamp_integ(cfg[1]);
		next_acq   = (cfg[0] > TW'(`ACQ_DELAY_MAX_US)) ? TW'(`ACQ_DELAY_MAX_US) : cfg[0]; // R5
		next_b1    = EW'(busy1_us(next_integ)) + EW'(next_acq); // R4
		next_b2    = next_b1 + EW'(next_integ);
		next_b3    = next_b2 + EW'(FINAL_BUSY_US);
		next_cs_ok = cfg[4] != '0 && cfg[4] < next_integ; // R14
	end

	// settings frozen for the whole cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{b1, b2, b3, ssd, ssw, per, cs_hi} <= '0;
			cs_ok <= 1'b0;
		end else if (go) begin
			b1      <= next_b1;
			b2      <= next_b2;
			b3      <= next_b3;
			ssd     <= cfg[2];
			ssw     <= cfg[3];
			per     <= cfg[4];
			cs_hi   <= cfg[4] - (cfg[4] >> 1); // R17
			cs_ok   <= next_cs_ok;
		end
	end

	// cycle state machine
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= S_IDLE;
			lead_cnt <= 2'h0;
		end else begin
			case (state)
				S_IDLE: begin
					if (go) begin
						state    <= S_LEAD;
						lead_cnt <= LEAD_CYC;
					end
				end
				S_LEAD: begin
					if (lead_cnt == 2'h0) begin
						state <= S_RUN;
					end else begin
						lead_cnt <= lead_cnt - 1'b1; // R8
					end
				end
				S_RUN: begin
					if (tick && next_el >= b3) begin
						state <= S_XFER; // R4
					end
				end
				S_XFER: begin
					if (xfer_ack) begin
						state <= S_IDLE; // R18
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// microseconds since time zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			elapsed <= '0;
		end else if (restart) begin
			elapsed <= '0;
		end else if (state == S_RUN && tick) begin
			elapsed <= next_el; // R19
		end
	end

	// ----------------------------------------------------------------
	// strobes
	// ----------------------------------------------------------------
	// repeating strobe period tracking
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_live <= 1'b0;
			cs_pos  <= '0;
		end else if (state != S_RUN && !restart) begin
			cs_live <= 1'b0;
		end else if (restart) begin
			cs_live <= cs_ok && b1 == '0; // R12
			cs_pos  <= '0;
		end else if (tick) begin
			if (!cs_live && cs_ok && next_el == b1) begin
				cs_live <= 1'b1; // R12
				cs_pos  <= '0;
			end else if (cs_live && cs_pos + 1'b1 == per) begin
				cs_pos  <= '0;
				cs_live <= b2 - next_el >= EW'(per); // R13 R17
			end else if (cs_live) begin
				cs_pos <= cs_pos + 1'b1;
			end
		end
	end

	// registered outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			single_strobe    <= 1'b0;
			repeating_strobe <= 1'b0;
			acq_busy         <= 1'b0;
		end else begin
			single_strobe <= state == S_RUN && elapsed >= EW'(ssd) && // R9
				elapsed - EW'(ssd) < EW'(ssw) && elapsed < b2; // R10 R11
			repeating_strobe <= state == S_RUN && cs_live && cs_pos < cs_hi; // R17
			acq_busy         <= state != S_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_ss_rise: assert property ( // R9
		state == S_RUN && elapsed == EW'(ssd) && ssw != '0 && elapsed < b2 |=> single_strobe)
		else $error("single strobe missed its delay");
	chk_ss_cut: assert property (state == S_RUN && elapsed >= b2 |=> !single_strobe) // R11
		else $error("single strobe high after integration");
	chk_cs_window: assert property (repeating_strobe |-> $past(in_integ)) // R12
		else $error("repeating strobe outside integration");
	chk_cs_enable: assert property (state == S_RUN && !cs_ok |=> !repeating_strobe) // R14
		else $error("repeating strobe with period not below integration");
	chk_cs_whole: assert property ( // R13
		$fell(cs_live) && state == S_RUN |-> b2 - elapsed < EW'(per) || elapsed >= b2)
		else $error("repeating strobe stopped with a period still fitting");
	chk_xfer_hold: assert property (state == S_XFER && !xfer_ack |=> state == S_XFER) // R18
		else $error("cycle left transfer wait without release");
	chk_phase_order: assert property ( // R4
		$rose(state == S_XFER) |-> $past(elapsed) + 1'b1 >= b3 && b3 > b2 && b2 > b1)
		else $error("cycle ended before final busy");
	chk_trigger_zero: assert property ( // R1
		go && LEAD_CYC == 2'h0 |=> restart ##1 state == S_RUN && elapsed == '0)
		else $error("trigger did not start time zero");
endmodule : acq_sequencer

// *** design/acq_timing_map.svh ***
// Purpose: named offsets, fields, reset values and timing counts of the sequencer
// Assumes: 40 MHz clock; register data is 32 bits wide on classic Wishbone
// Notes:   all times are in the unit that their name carries
`ifndef ACQ_TIMING_MAP_SVH
`define ACQ_TIMING_MAP_SVH

// ----------------------------------------------------------------
// clock and trigger timing
// ----------------------------------------------------------------
`define ACQ_CLK_PERIOD_NS     25
`define ACQ_US_NS             1000
`define ACQ_CYC_PER_US        (`ACQ_US_NS / `ACQ_CLK_PERIOD_NS)
`define ACQ_TRIG_MIN_HIGH_NS  10
`define ACQ_TRIG_EVT_MIN_NS   20
`define ACQ_TRIG_EVT_MAX_NS   30
`define ACQ_TRIG_EVT_MIN_CYC  ((`ACQ_TRIG_EVT_MIN_NS + `ACQ_CLK_PERIOD_NS - 1) / `ACQ_CLK_PERIOD_NS)
`define ACQ_TRIG_EVT_MAX_CYC  (`ACQ_TRIG_EVT_MAX_NS / `ACQ_CLK_PERIOD_NS)
`define ACQ_DELAY_MAX_US      335500

// ----------------------------------------------------------------
// sensor variants: busy constants and integration limits
// ----------------------------------------------------------------
`define ACQ_V0_BUSY_SPLIT_US  218
`define ACQ_V0_BUSY1_BASE_US  219
`define ACQ_V0_BUSY1_MIN_US   1
`define ACQ_V0_BUSY2_US       218
`define ACQ_V0_INTEG_MIN_US   1
`define ACQ_V0_INTEG_MAX_US   6000000
`define ACQ_V1_BUSY1_US       3706
`define ACQ_V1_BUSY2_US       3706
`define ACQ_V1_INTEG_MIN_US   3800
`define ACQ_V1_INTEG_MAX_US   10000000
`define ACQ_V2_BUSY1_NS       15
`define ACQ_V2_BUSY1_CYC      ((`ACQ_V2_BUSY1_NS + `ACQ_CLK_PERIOD_NS - 1) / `ACQ_CLK_PERIOD_NS)
`define ACQ_V2_BUSY2_US       4977
`define ACQ_V2_INTEG_MIN_US   7200
`define ACQ_V2_INTEG_MAX_US   5000000

// ----------------------------------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------------------------------
`define ACQ_REG_CTRL          8'h00
`define ACQ_REG_ACQ_DELAY     8'h04
`define ACQ_REG_INTEG         8'h08
`define ACQ_REG_SS_DELAY      8'h0c
`define ACQ_REG_SS_WIDTH      8'h10
`define ACQ_REG_RP_PERIOD     8'h14
`define ACQ_REG_STATUS        8'h18
`define ACQ_CFG_COUNT         5
`define ACQ_CTRL_SWTRIG_BIT   4
`define ACQ_CTRL_XFER_BIT     8
`define ACQ_MODE_RESET        2'h0
`define ACQ_CFG_RESET         24'h000000
`define ACQ_ST_BUSY_BIT       0
`define ACQ_ST_INTEG_BIT      1
`define ACQ_ST_XFER_BIT       2
`define ACQ_ST_CSOK_BIT       3

`endif

// *** design/acq_timing_pkg.sv ***
// Purpose: shared types of the acquisition sequencer
// Assumes: nothing beyond the map header
// Notes:   trigger mode codes follow the enum order
package acq_timing_pkg;
	typedef logic [31:0] word_t;
	typedef enum logic [1:0] {TRIG_SOFT, TRIG_EDGE, TRIG_LEVEL} trig_mode_t;
	typedef enum {S_IDLE, S_LEAD, S_RUN, S_XFER} seq_state_t;
endpackage : acq_timing_pkg

// *** design/us_tick.sv ***
// Purpose: one-cycle enable every microsecond, realignable to a new time zero
// Assumes: DIV is at least 2
// Notes:   first tick comes DIV cycles after restart
`include "acq_timing_map.svh"
module us_tick #(
	parameter int DIV = `ACQ_CYC_PER_US
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// control
	input  wire logic restart,
	output logic      tick
);
	localparam int CW = $clog2(DIV);
	logic [CW-1:0] cnt;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	// count within one microsecond
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
		end else if (restart || cnt == CW'(DIV - 1)) begin // R19
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
	assign tick = !restart && cnt == CW'(DIV - 1);

	chk_tick_spacing: assert property ( // R19
		@(posedge clk) disable iff (!rst_b) tick |=> !tick [*8])
		else $error("microsecond ticks too close");
endmodule : us_tick

// *** design/trig_edge.sv ***
// Purpose: rising-edge detector on the external trigger pin
// Assumes: the pin is synchronous to clk and stays high at least one sample
// Notes:   the event pulse comes one clock after the sampled rise
`include "acq_timing_map.svh"
module trig_edge (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// pin and gate
	input  wire logic ext_trig_in,
	input  wire logic enable,
	output logic      trig_event
);
	logic trig_q;

	// ----------------------------------------------------------------
	// sample and detect
	// ----------------------------------------------------------------
	// previous level and edge pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			trig_q     <= 1'b0;
			trig_event <= 1'b0;
		end else begin
			trig_q     <= ext_trig_in; // R19 R2
			trig_event <= enable && ext_trig_in && !trig_q; // R1 R3
		end
	end

	chk_edge_event: assert property ( // R3
		@(posedge clk) disable iff (!rst_b)
		enable && ext_trig_in && !$past(ext_trig_in) |=> trig_event)
		else $error("rising edge gave no event in one cycle");
	chk_event_source: assert property ( // R1
		@(posedge clk) disable iff (!rst_b)
		trig_event |-> $past(ext_trig_in) && !$past(trig_q) && $past(enable))
		else $error("event without a rising edge");
endmodule : trig_edge

// *** verif/ext_trigger_src.sv ***
// Purpose: external trigger source facing the sequencer's trigger pin
// Assumes: the pin is sampled on the rising edge of clk
// Notes:   idle low; pulses last whole clock periods
module ext_trigger_src (
	// clock
	input  wire logic clk,
	// trigger pin
	output logic      ext_trig
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// pin driver
	// ----------------------------------------------------------------
	// pin idles low from time zero
	initial ext_trig = 1'b0;

	// one rising edge, then at least one full cycle high (25 ns)
	task automatic pulse(input int high_cyc);
		@(posedge clk);
		ext_trig <= 1'b1;
		repeat ((high_cyc < 1) ? 1 : high_cyc) @(posedge clk);
		ext_trig <= 1'b0;
	endtask : pulse
endmodule : ext_trigger_src

// *** verif/test_acquisition_trigger_strobe_timing.sv ***
// Purpose: self-checking bench for the acquisition sequencer, variant 0
// Assumes: 40 MHz clock; registers on classic Wishbone
// Notes:   output edges are counted in cycles and rounded to microseconds
module test_acquisition_trigger_strobe_timing
	import acq_timing_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic       clk = 1'b0;
	logic       rst_b;
	logic       cyc;
	logic       stb;
	logic       we;
	logic [7:0] adr;
	logic [3:0] sel;
	word_t      wdat;
	word_t      rdat;
	word_t      q;
	logic       ack;
	logic       ext_trig;
	logic       ss;
	logic       rp;
	logic       busy;
	int         miscompares;
	int         checked;
	int         ss_up;
	int         ss_dn;
	int         rp_up;
	int         rp_f1;
	int         rp_dn;
	int         rp_cnt;
	int         bz_up;

	// 25 ns clock
	always #12.5 clk = ~clk;

	// design under test and trigger source
	acq_sequencer #(.VARIANT(0)) dut (
		.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ext_trig_in(ext_trig), .single_strobe(ss),
		.repeating_strobe(rp), .acq_busy(busy));
	ext_trigger_src src (.clk(clk), .ext_trig(ext_trig));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input word_t got, input word_t exp, input string m);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h", $time, m, got);
		end
	endtask : chk

	task automatic chk_n(input int got, input int exp, input string m);
		checked++;
		if (got != exp) begin
			miscompares++;
			$display("BAD %0t %s got %0d", $time, m, got);
		end
	endtask : chk_n

	// classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input word_t d, output word_t r);
		int n;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= 4'hf;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 64);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 64) chk_n(n, 0, "no ack");
	endtask : wb

	task automatic cfg(input word_t acq, input word_t integ, input word_t ssd,
			input word_t ssw, input word_t per);
		wb(1'b1, 8'h04, acq, q);
		wb(1'b1, 8'h08, integ, q);
		wb(1'b1, 8'h0c, ssd, q);
		wb(1'b1, 8'h10, ssw, q);
		wb(1'b1, 8'h14, per, q);
	endtask : cfg

	function automatic int us(input int c);
		return (c + 20) / 40;
	endfunction : us

	// records first and last strobe edges over a span of cycles
	task automatic watch(input int ncyc);
		logic ps;
		logic pr;
		ps = 1'b0;
		pr = 1'b0;
		ss_up = -1;
		ss_dn = -1;
		rp_up = -1;
		rp_f1 = -1;
		rp_dn = -1;
		rp_cnt = 0;
		bz_up = -1;
		for (int n = 1; n <= ncyc; n++) begin
			@(posedge clk);
			#1;
			if (ss === 1'b1 && ps === 1'b0 && ss_up < 0) ss_up = n;
			if (ss === 1'b0 && ps === 1'b1) ss_dn = n;
			if (rp === 1'b1 && pr === 1'b0) begin
				rp_cnt++;
				if (rp_up < 0) rp_up = n;
			end
			if (rp === 1'b0 && pr === 1'b1) begin
				rp_dn = n;
				if (rp_f1 < 0) rp_f1 = n;
			end
			if (busy === 1'b1 && bz_up < 0) bz_up = n;
			ps = ss;
			pr = rp;
		end
	endtask : watch

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		for (int a = 0; a <= 'h1c; a += 4) begin
			wb(1'b0, 8'(a), 32'h0, q);
			chk(q, 32'h0, "reset value");
		end
		wb(1'b1, 8'h04, 32'hffffffff, q);
		wb(1'b0, 8'h04, 32'h0, q);
		chk(q, 32'h00ffffff, "delay field width");
		wb(1'b1, 8'h04, 32'h00051e8c, q);
		wb(1'b0, 8'h04, 32'h0, q);
		chk(q, 32'h00051e8c, "largest delay");
		wb(1'b1, 8'h40, 32'h5, q);
		wb(1'b0, 8'h40, 32'h0, q);
		chk(q, 32'h0, "unmapped read");
	endtask : t_regs

	task automatic t_soft;
		cfg(32'h2, 32'hda, 32'h5, 32'h3, 32'h4);
		wb(1'b1, 8'h00, 32'h10, q);
		watch(437 * 40);
		chk_n(us(ss_up), 5, "strobe rise");
		chk_n(us(ss_dn), 8, "strobe width");
		chk_n(us(rp_up), 1 + 2, "repeat start");
		chk_n(us(rp_f1) - us(rp_up), 2, "repeat duty");
		chk_n(rp_cnt, (218 - 4) / 4 + 1, "whole periods");
		chk_n(us(rp_dn), 3 + 53 * 4 + 2, "last period");
		wb(1'b0, 8'h18, 32'h0, q);
		chk(q & 32'h6, 32'h0, "final busy running");
		repeat (160) @(posedge clk);
		wb(1'b1, 8'h00, 32'h10, q);
		wb(1'b0, 8'h18, 32'h0, q);
		chk(q & 32'he, 32'hc, "awaiting release");
		chk({31'h0, busy}, 32'h1, "busy held");
		wb(1'b1, 8'h00, 32'h100, q);
		wb(1'b0, 8'h18, 32'h0, q);
		chk(q & 32'h7, 32'h0, "idle after release");
		chk({31'h0, busy}, 32'h0, "busy dropped");
	endtask : t_soft

	task automatic t_edge;
		wb(1'b1, 8'h00, 32'h1, q);
		cfg(32'h0, 32'hc8, 32'hc8, 32'h64, 32'hc8);
		wb(1'b1, 8'h00, 32'h11, q);
		repeat (8) @(posedge clk);
		chk({31'h0, busy}, 32'h0, "command in edge mode");
		fork
			src.pulse(1);
			watch(440 * 40);
		join
		chk_n((bz_up > 0 && bz_up <= 4) ? 1 : 0, 1, "event latency");
		chk_n(us(ss_up), 200, "edge strobe rise");
		chk_n(us(ss_dn), (219 - 200) + 200, "strobe cut");
		chk_n(rp_cnt, 0, "period equal to integ");
		wb(1'b0, 8'h18, 32'h0, q);
		chk(q & 32'hc, 32'h4, "repeat not enabled");
		wb(1'b1, 8'h00, 32'h101, q);
	endtask : t_edge

	task automatic t_level;
		wb(1'b1, 8'h00, 32'h2, q);
		src.pulse(3);
		repeat (200) @(posedge clk);
		chk({31'h0, busy}, 32'h0, "level mode idle");
		wb(1'b0, 8'h00, 32'h0, q);
		chk(q, 32'h2, "mode readback");
	endtask : t_level

	// ----------------------------------------------------------------
	// sequence, watchdog and verdict
	// ----------------------------------------------------------------
	task automatic wrap_up;
		if (miscompares == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// reset for 20 cycles, then the scenarios
	initial begin
		rst_b = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		miscompares = 0;
		checked = 0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_soft();
		t_edge();
		t_level();
		wrap_up();
	end

	// cuts a hang short, well past the expected 36k cycles
	initial begin
		#(60000 * 25);
		miscompares++;
		$display("BAD %0t watchdog expired", $time);
		wrap_up();
	end
endmodule : test_acquisition_trigger_strobe_timing
